// ==== design/bpm_pkg.sv ====
// Package for the beacon window merge logic: constants, types, register map.
// Assumes all offsets are in microseconds inside a 65536 us superframe.
package bpm_pkg;
    // ****************************************
    // Timing and protocol constants
    // ****************************************
    localparam logic [15:0] GUARD_US = 16'h000c;
    localparam logic [15:0] GUARD2_US = 16'h0018;
    localparam logic [15:0] SLOT_US = 16'h0055;
    localparam int RES_SHIFT = 8;
    localparam logic [15:0] RES_ROUND = 16'h00ff;
    localparam logic [7:0] SIG_SLOTS = 8'h02;
    localparam logic [7:0] MAX_LEN = 8'h60;
    localparam logic [3:0] LOST_LIMIT = 4'h3;
    localparam logic [7:0] INIT_CD = 8'h03;
    localparam logic [15:0] HALT_OFF = 16'hffff;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_SLOT = 8'h04;
    localparam logic [7:0] ADR_LEN = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0c;
    localparam logic [7:0] ADR_SWEL = 8'h10;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [7:0] SLOT_RST = 8'h02;
    localparam logic [7:0] LEN_RST = 8'h03;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SWITCH = 2'b01,
        ST_MOVE = 2'b11,
        ST_SETTLE = 2'b10
    } bpm_st_e;
    typedef struct packed {
        logic [7:0] cd;
        logic [15:0] off;
        logic [7:0] slot;
    } bpm_sw_s;
    typedef struct packed {
        logic vld;
        logic hdr_ok;
        logic fcs_ok;
        logic sig;
        logic [15:0] start;
        logic [7:0] len;
        logic [7:0] hi;
        logic sw_pres;
        bpm_sw_s sw;
    } bpm_rx_s;
    typedef struct packed {
        logic en;
        logic [7:0] start;
        logic [7:0] cnt;
    } bpm_resv_s;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bpm_wbi_s;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } bpm_wbo_s;
endpackage

// ==== design/bpm_merge.sv ====
// Beacon window merge logic: foreign window detection, relocation and switch element.
// Assumes a receiver that reports each beacon once and a superframe end pulse.
//
// Notes on behaviour
// - Foreign beacon needs good header and frame checks, misaligned start, not signaling.
// - Starts closer than twice the guard interval count as aligned.
// - Overlap when own start inside foreign window or foreign start inside own.
// - Missing foreign beacon reuses last contents for up to the lost limit.
// - Own start inside foreign window while idle: adopt its start, shift slot or join normally.
// - After such a move, delay signaling beacon by a random count of superframes.
// - Non-overlapping foreign window gets a reservation covering its largest length plus one.
// - Relocate to non-overlapping window promptly, but not in a superframe where its beacon carries a switch element.
// - With a reservation, listen through reserved slots; keep own slot steady.
// - First foreign beacon while idle builds a fresh switch element.
// - Foreign gap well beyond own offset recomputes the whole element.
// - Gap near own offset refreshes offset, raises slot offset, restarts or decrements.
// - Neighbour element heard without own: copy countdown, offset, larger slot offset.
// - Neighbour offset much larger: adopt neighbour element.
// - Offsets agree and neighbour slot offset larger: adopt neighbour element.
// - Offsets agree, no target beacons, smaller neighbour countdown: copy offset, decrement.
// - Otherwise keep offsets and decrement countdown each superframe.
// - Keep sending element until done or halted; halt on earlier move or neighbour halt.
// - Halt element carries offset 65535, slot offset zero, initial countdown.
// - Countdown zero at superframe end: shift start, drop element and reservation.
// - New slot is prior plus slot offset, normal join if at or past maximum.
// - Foreign element with slot offset extends own window length, capped at maximum.
// - Normal join takes a slot after highest occupied one, within maximum length.
`timescale 1ns/1ns
module bpm_merge (
    input wire logic I_MCLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    input wire bpm_pkg::bpm_wbi_s I_WB,
    output bpm_pkg::bpm_wbo_s O_WB,
    input wire bpm_pkg::bpm_rx_s I_RX,
    input wire logic I_SF_END,
    output bpm_pkg::bpm_sw_s O_SW,
    output logic O_SW_INCL,
    output bpm_pkg::bpm_resv_s O_RESV,
    output logic O_LISTEN_RESV,
    output logic O_MOVE,
    output logic [15:0] O_MOVE_OFF,
    output logic [7:0] O_SLOT,
    output logic O_JOIN_NORMAL,
    output logic O_SIG_HOLD,
    output logic [7:0] O_WIN_LEN
);
    import bpm_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // Offsets wrap at the superframe, so nearness is checked both ways.
    function automatic logic near(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] df;
        df = a - b;
        near = (df < GUARD2_US) || ((16'h0000 - df) < GUARD2_US);
    endfunction

    function automatic logic [15:0] len_us(input logic [7:0] n);
        len_us = {8'h00, n} * SLOT_US;
    endfunction

    // A shift below the signaling slots means nothing to gain, so zero is used.
    function automatic logic [7:0] cslot(input logic [7:0] hi, input logic norm);
        cslot = (norm || hi < SIG_SLOTS) ? 8'h00 : hi + 8'h01 - SIG_SLOTS;
    endfunction

    function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
        max8 = (a > b) ? a : b;
    endfunction

    // Compared before the increment so a top slot number cannot wrap to zero.
    function automatic logic [7:0] jslot(input logic [7:0] hi);
        jslot = (hi < MAX_LEN - 8'h01) ? hi + 8'h01 : MAX_LEN - 8'h01;
    endfunction

    // ****************************************
    // Reset release and state
    // ****************************************
    typedef struct packed {
        bpm_wbo_s wb;
        logic [1:0] ctrl;
        logic [7:0] slot;
        logic [7:0] base_len;
        logic [7:0] win_len;
        bpm_st_e st;
        bpm_sw_s sw;
        logic incl;
        logic halted;
        logic al_seen;
        logic al_sw;
        logic al_early;
        logic al_tgt;
        logic [15:0] al_off;
        logic [7:0] al_hi;
        logic [7:0] al_len;
        logic ov_seen;
        logic [15:0] ov_off;
        logic [7:0] ov_hi;
        logic nb_seen;
        logic nb_halt;
        bpm_sw_s nb;
        logic [7:0] ext_len;
        logic lst_vld;
        logic [3:0] age;
        logic [15:0] lst_off;
        logic [7:0] lst_hi;
        logic [7:0] lst_len;
        bpm_resv_s resv;
        logic move;
        logic join_n;
        logic [15:0] move_off;
        logic [7:0] sig_wait;
        logic sig_hold;
        logic [15:0] lfsr;
    } bpm_state_s;

    logic [1:0] rst_sync_q;
    logic rst_n;
    bpm_state_s q;
    bpm_state_s d;

    // Two stages release the asynchronous reset in step with the clock.
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************
    // Beacon decode
    // ****************************************
    logic rx_ok;
    logic alien;
    logic own_in;
    logic al_in;
    logic use_lst;
    logic e_seen;
    logic [15:0] e_off;
    logic [7:0] e_hi;
    logic [7:0] e_len;
    logic [7:0] cs;
    logic [8:0] ns5;
    logic [8:0] ns21;
    logic [8:0] ext_sum;

    // Signaling slot copies and damaged frames never count as foreign.
    assign rx_ok = q.ctrl[0] && I_RX.vld && I_RX.hdr_ok && I_RX.fcs_ok && !I_RX.sig;
    assign alien = rx_ok && !near(I_RX.start, 16'h0000);
    // The 17-bit sum passing the superframe means the window covers own start.
    assign own_in = ({1'b0, I_RX.start} + {1'b0, len_us(I_RX.len)}) > 17'h10000;
    assign al_in = I_RX.start < len_us(q.win_len);
    // A foreign window heard before stands in for a missed beacon.
    assign use_lst = !q.al_seen && q.lst_vld && (q.age < LOST_LIMIT);
    assign e_seen = q.al_seen || use_lst;
    assign e_off = q.al_seen ? q.al_off : q.lst_off;
    assign e_hi = q.al_seen ? q.al_hi : q.lst_hi;
    assign e_len = q.al_seen ? q.al_len : q.lst_len;
    assign cs = cslot(e_hi, q.ctrl[1]);
    assign ns5 = {1'b0, q.slot} + 9'h001 + {1'b0, q.ov_hi} - {1'b0, SIG_SLOTS};
    assign ns21 = {1'b0, q.slot} + {1'b0, q.sw.slot};
    // Nine bits so a large slot offset plus length saturates instead of wrapping.
    assign ext_sum = {1'b0, I_RX.sw.slot} + {1'b0, I_RX.len};

    // ****************************************
    // Next state
    // ****************************************
    // Bus, beacon gathering and the superframe step all write one copy.
    always_comb begin
        d = q;
        d.move = 1'b0;
        d.join_n = 1'b0;
        d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
        // Single-cycle answer; an unmapped address reads zero and ignores writes.
        d.wb.ack = 1'b0;
        if (I_WB.cyc && I_WB.stb && !q.wb.ack) begin
            d.wb.ack = 1'b1;
            d.wb.dat = 32'h0000_0000;
            case ({I_WB.adr[7:2], 2'b00})
                ADR_CTRL: begin
                    d.wb.dat = {30'h0, q.ctrl};
                    if (I_WB.we && I_WB.sel[0]) begin
                        d.ctrl = I_WB.dat[1:0];
                    end
                end
                ADR_SLOT: begin
                    d.wb.dat = {24'h0, q.slot};
                    if (I_WB.we && I_WB.sel[0]) begin
                        d.slot = I_WB.dat[7:0];
                    end
                end
                ADR_LEN: begin
                    d.wb.dat = {24'h0, q.base_len};
                    if (I_WB.we && I_WB.sel[0]) begin
                        d.base_len = I_WB.dat[7:0];
                    end
                end
                ADR_STAT: begin
                    d.wb.dat = {16'h0, q.win_len, 2'h0, q.st, q.sig_wait != 8'h00,
                                q.resv.en, q.halted, q.incl};
                end
                ADR_SWEL: begin
                    d.wb.dat = {q.sw.off, q.sw.slot, q.sw.cd};
                end
                default: begin
                    d.wb.dat = 32'h0000_0000;
                end
            endcase
        end

        // Foreign beacons covering own start trigger a move when idle; those starting past own window feed the merge.
        if (alien && own_in) begin
            d.ov_seen = 1'b1;
            d.ov_off = I_RX.start;
            d.ov_hi = max8(q.ov_hi, I_RX.hi);
        end else if (alien && !al_in) begin
            d.al_seen = 1'b1;
            if (!q.al_seen || I_RX.start > q.al_off) begin
                d.al_off = I_RX.start;
            end
            d.al_hi = max8(q.al_hi, I_RX.hi);
            d.al_len = max8(q.al_len, I_RX.len);
            if (I_RX.sw_pres) begin
                d.al_sw = 1'b1;
            end
            if (near(I_RX.start, q.sw.off)) begin
                d.al_tgt = 1'b1;
            end
            if (q.incl && I_RX.sw_pres && I_RX.sw.cd < q.sw.cd) begin
                d.al_early = 1'b1;
            end
            if (I_RX.sw_pres && I_RX.sw.slot != 8'h00) begin
                d.ext_len = max8(q.ext_len, ext_sum[8] ? MAX_LEN : ext_sum[7:0]);
            end
        end
        // Aligned beacons with an element come from neighbours.
        if (rx_ok && !alien && I_RX.sw_pres) begin
            d.nb_seen = 1'b1;
            if (I_RX.sw.off == HALT_OFF) begin
                d.nb_halt = 1'b1;
            end else if (!q.nb_seen || I_RX.sw.off > q.nb.off) begin
                d.nb = I_RX.sw;
            end
        end

        // ****************************************
        // Superframe step
        // ****************************************
        // A beacon in the step cycle is discarded: the receiver cannot report then.
        if (I_SF_END && q.ctrl[0]) begin
            if (q.sig_wait != 8'h00) begin
                d.sig_wait = q.sig_wait - 8'h01;
            end
            case (q.st)
                ST_IDLE: begin
                    if (q.ov_seen) begin
                        d.move = 1'b1;
                        d.move_off = q.ov_off;
                        if (q.ctrl[1] || ns5 >= {1'b0, MAX_LEN}) begin
                            d.join_n = 1'b1;
                            d.slot = jslot(q.ov_hi);
                        end else begin
                            d.slot = ns5[7:0];
                        end
                        d.sig_wait = 8'(q.lfsr % ({8'h00, q.win_len} + 16'h0001));
                    end else if (e_seen && !q.al_sw) begin
                        d.sw = '{cd: INIT_CD, off: e_off, slot: cs};
                        d.incl = 1'b1;
                        d.st = ST_SWITCH;
                    end else if (q.nb_seen && !q.nb_halt) begin
                        d.sw.cd = q.nb.cd;
                        d.sw.off = q.nb.off;
                        d.sw.slot = q.ctrl[1] ? 8'h00 : max8(cs, q.nb.slot);
                        d.incl = 1'b1;
                        d.st = ST_SWITCH;
                    end
                end
                ST_SWITCH: begin
                    if (q.halted) begin
                        // The halt element went out once; normal rules resume.
                        d.halted = 1'b0;
                        d.incl = 1'b0;
                        d.st = ST_IDLE;
                    end else if (q.sw.cd == 8'h00) begin
                        d.move = 1'b1;
                        d.move_off = q.sw.off;
                        d.incl = 1'b0;
                        d.st = ST_MOVE;
                        if (q.sw.slot != 8'h00 && ns21 < {1'b0, MAX_LEN}) begin
                            d.slot = ns21[7:0];
                        end else begin
                            d.join_n = 1'b1;
                            d.slot = jslot(e_hi);
                        end
                    end else if (q.al_early || q.nb_halt) begin
                        d.sw = '{cd: INIT_CD, off: HALT_OFF, slot: 8'h00};
                        d.halted = 1'b1;
                    end else if (e_seen && (e_off > q.sw.off + GUARD2_US)) begin
                        d.sw = '{cd: INIT_CD, off: e_off, slot: cs};
                    end else if (e_seen && near(e_off, q.sw.off)) begin
                        d.sw.off = e_off;
                        if (cs > q.sw.slot) begin
                            d.sw.slot = cs;
                            d.sw.cd = INIT_CD;
                        end else begin
                            d.sw.cd = q.sw.cd - 8'h01;
                        end
                    end else if (q.nb_seen && (q.nb.off > q.sw.off + GUARD2_US)) begin
                        d.sw.cd = q.nb.cd;
                        d.sw.off = q.nb.off;
                        d.sw.slot = q.ctrl[1] ? 8'h00 : max8(cs, q.nb.slot);
                    end else if (q.nb_seen && near(q.nb.off, q.sw.off)
                                 && q.nb.slot > q.sw.slot) begin
                        d.sw.cd = q.nb.cd;
                        d.sw.off = q.nb.off;
                        d.sw.slot = q.ctrl[1] ? 8'h00 : max8(cs, q.nb.slot);
                    end else if (q.nb_seen && near(q.nb.off, q.sw.off) && !q.al_tgt
                                 && q.nb.cd < q.sw.cd) begin
                        d.sw.off = q.nb.off;
                        d.sw.cd = q.sw.cd - 8'h01;
                    end else begin
                        d.sw.cd = q.sw.cd - 8'h01;
                    end
                end
                ST_MOVE: begin
                    // Two superframes of grace, in move then settle, before beaconing in the new window.
                    d.st = ST_SETTLE;
                end
                ST_SETTLE: begin
                    d.st = ST_IDLE;
                end
                default: begin
                    d.st = ST_IDLE;
                end
            endcase
            // Reservation tracks the largest foreign length until the move.
            d.resv.en = e_seen && (d.st == ST_IDLE || d.st == ST_SWITCH) && !d.move;
            d.resv.start = e_off[15:RES_SHIFT];
            d.resv.cnt = 8'((len_us(e_len) + RES_ROUND) >> RES_SHIFT) + 8'h01;
            if (max8(q.base_len, q.ext_len) > MAX_LEN) begin
                d.win_len = MAX_LEN;
            end else begin
                d.win_len = max8(q.base_len, q.ext_len);
            end
            if (q.al_seen) begin
                d.lst_vld = 1'b1;
                d.age = 4'h0;
                d.lst_off = q.al_off;
                d.lst_hi = q.al_hi;
                d.lst_len = q.al_len;
            end else if (q.lst_vld) begin
                d.age = q.age + 4'h1;
                d.lst_vld = (q.age + 4'h1) < LOST_LIMIT;
            end
            d.al_seen = 1'b0;
            d.al_sw = 1'b0;
            d.al_early = 1'b0;
            d.al_tgt = 1'b0;
            d.al_hi = 8'h00;
            d.al_len = 8'h00;
            d.ov_seen = 1'b0;
            d.ov_hi = 8'h00;
            d.nb_seen = 1'b0;
            d.nb_halt = 1'b0;
            d.ext_len = 8'h00;
        end
        // The hold flag is registered so the output comes from a flip-flop.
        d.sig_hold = (d.sig_wait != 8'h00);
    end

    // All state except the reset synchronizer freezes while the clock enable is low.
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
            q.slot <= SLOT_RST;
            q.base_len <= LEN_RST;
            q.win_len <= LEN_RST;
            q.lfsr <= LFSR_SEED;
        end else if (I_CE) begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign O_WB = q.wb;
    assign O_SW = q.sw;
    assign O_SW_INCL = q.incl;
    assign O_RESV = q.resv;
    assign O_LISTEN_RESV = q.resv.en;
    assign O_MOVE = q.move;
    assign O_MOVE_OFF = q.move_off;
    assign O_SLOT = q.slot;
    assign O_JOIN_NORMAL = q.join_n;
    assign O_SIG_HOLD = q.sig_hold;
    assign O_WIN_LEN = q.win_len;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!rst_n);

    sequence s_step;
        I_CE && I_SF_END && q.ctrl[0];
    endsequence
    sequence s_fresh;
        s_step ##0 (q.st == ST_IDLE && !q.ov_seen && q.al_seen && !q.al_sw);
    endsequence
    sequence s_zero;
        s_step ##0 (q.st == ST_SWITCH && !q.halted && q.sw.cd == 8'h00);
    endsequence

    AST_SIG_NOT_ALIEN: assert property (
        I_CE && I_RX.vld && I_RX.sig && !q.al_seen && !q.ov_seen |=> !q.al_seen && !q.ov_seen)
        else $error("Signaling beacon taken as foreign.");
    AST_ALIGNED: assert property (
        I_CE && rx_ok && I_RX.start < GUARD2_US && !q.al_seen && !I_SF_END |=> !q.al_seen)
        else $error("Aligned beacon taken as foreign.");
    AST_OWN_IN: assert property (
        I_CE && alien && own_in && !I_SF_END |=> q.ov_seen)
        else $error("Overlap covering own start missed.");
    AST_MOVE_PULSE: assert property (
        q.move && I_CE |=> !q.move)
        else $error("Move pulse longer than one cycle.");
    AST_FRESH: assert property (
        s_fresh |=> q.incl && q.sw.cd == INIT_CD && q.sw.off == $past(q.al_off))
        else $error("Fresh switch element wrong.");
    AST_HALT: assert property (
        s_step ##0 (q.st == ST_SWITCH && !q.halted && q.sw.cd != 8'h00
        && (q.al_early || q.nb_halt)) |=> q.sw.off == HALT_OFF && q.sw.slot == 8'h00
        && q.sw.cd == INIT_CD && q.incl)
        else $error("Halt element wrong.");
    AST_RELOC: assert property (
        s_zero |=> q.move && !q.incl && !q.resv.en && q.st == ST_MOVE)
        else $error("Relocation at zero countdown missed.");
    AST_LEN_CAP: assert property (
        q.win_len <= MAX_LEN)
        else $error("Window length above maximum.");
    AST_WB_ACK: assert property (
        q.wb.ack && I_CE |=> !q.wb.ack)
        else $error("Bus ack held two cycles.");
endmodule // bpm_merge

// ==== bench/bpm_peer.sv ====
// Neighbour model: beacon reports and superframe ends.
// Assumes one bench process calls its tasks.
`timescale 1ns/1ns
module bpm_peer (
    input wire logic i_clk,
    output bpm_pkg::bpm_rx_s o_rx,
    output logic o_sf_end
);
    import bpm_pkg::*;
    // Nothing is reported at time zero.
    initial begin
        o_rx = '0;
        o_sf_end = 1'b0;
    end
    // One report; then garbage so stale fields are never trusted.
    task automatic beacon(input bpm_rx_s b);
        @(posedge i_clk);
        o_rx <= b;
        @(posedge i_clk);
        o_rx <= {1'b0, ~b[$bits(b)-2:0]};
    endtask
    // Superframe end is a one-cycle pulse.
    task automatic sf();
        @(posedge i_clk);
        o_sf_end <= 1'b1;
        @(posedge i_clk);
        o_sf_end <= 1'b0;
    endtask
endmodule // bpm_peer

// ==== bench/tb_top.sv ====
// Testbench: bus and beacon scenarios against an integer model.
// Assumes the peer model drives beacon reports.
`timescale 1ns/1ns
module tb_top;
    import bpm_pkg::*;
    // ********
    // Signals
    // ********
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    bpm_wbi_s wbi = '0;
    bpm_wbo_s wbo;
    bpm_rx_s rx;
    bpm_sw_s sw;
    bpm_resv_s resv;
    logic sfe, incl, lst, mv, jn, sgh;
    logic [15:0] moff;
    logic [7:0] slot, wlen;
    logic [31:0] q;
    logic [15:0] lfsr = 16'd92;
    logic [7:0] ad [5] = '{ADR_CTRL, ADR_SLOT, ADR_LEN, ADR_STAT, 8'h14};
    logic [31:0] rv [5] = '{32'h1, 32'h2, 32'h3, 32'h300, 32'h0};
    int mismatches = 0;
    int num_checks = 0;
    int m_slot;
    // Clock of 4 ns period.
    always #2 clk = ~clk;
    bpm_merge bpm_merge_i (.I_MCLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_WB(wbi),
        .O_WB(wbo), .I_RX(rx), .I_SF_END(sfe), .O_SW(sw), .O_SW_INCL(incl), .O_RESV(resv),
        .O_LISTEN_RESV(lst), .O_MOVE(mv), .O_MOVE_OFF(moff), .O_SLOT(slot),
        .O_JOIN_NORMAL(jn), .O_SIG_HOLD(sgh), .O_WIN_LEN(wlen));
    bpm_peer bpm_peer_i (.i_clk(clk), .o_rx(rx), .o_sf_end(sfe));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic bpm_rx_s mk(input logic [15:0] st, input logic [7:0] hi);
        return '{1'b1, 1'b1, 1'b1, 1'b0, st, 8'h4, hi, 1'b0, 32'h0};
    endfunction
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask
    // Request held until ack is sampled; a stuck slave ends the wait.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbi <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do begin
            @(posedge clk);
            n++;
        end while (wbo.ack !== 1'b1 && n < 50);
        q = wbo.dat;
        chk_bit(wbo.ack, 1'b1);
        wbi <= '0;
    endtask
    // Outputs are settled just after the edge that takes the superframe end.
    task automatic step();
        bpm_peer_i.sf();
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog: the run needs far less than this.
    initial begin
        #40000;
        mismatches++;
        $display("MISMATCH t=%0t timeout", $time);
        print_verdict();
    end
    // Main sequence.
    initial begin
        bpm_rx_s b;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        wb(1'b1, 8'h14, 32'h5a);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ad[i], 32'h0);
            chk_val(q, rv[i]);
        end
        lfsr = nxt(lfsr);
        m_slot = 2 + lfsr[2:0];
        wb(1'b1, ADR_SLOT, m_slot);
        wb(1'b0, ADR_SLOT, 32'h0);
        chk_val(q, m_slot);
        $display("test regs done");
        // Bad checks, signaling beacons and aligned starts are ignored.
        for (int i = 0; i < 4; i++) begin
            b = mk(i == 3 ? 16'h0017 : 16'h4000, 8'h5);
            b.hdr_ok = (i != 0);
            b.fcs_ok = (i != 1);
            b.sig = (i == 2);
            bpm_peer_i.beacon(b);
            step();
            chk_bit(incl, 1'b0);
        end
        // With the clock enable low neither the beacon nor the step is taken.
        @(posedge clk);
        ce <= 1'b0;
        bpm_peer_i.beacon(mk(16'h4000, 8'h5));
        step();
        chk_bit(incl, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        $display("test refuse done");
        bpm_peer_i.beacon(mk(16'hff00, 8'h3));
        step();
        chk_val({mv, jn, moff}, {2'b10, 16'hff00});
        m_slot += 2;
        chk_val(slot, m_slot);
        repeat (4) step();
        chk_bit(sgh, 1'b0);
        $display("test overlap done");
        // Countdown runs down; one missed beacon is bridged.
        for (int k = 0; k < 4; k++) begin
            if (k != 2) bpm_peer_i.beacon(mk(16'h4000, 8'h5));
            step();
            chk_val(sw, {8'(3 - k), 16'h4000, 8'h4});
            chk_val({incl, lst, resv.en, resv.start, resv.cnt}, {3'b111, 8'h40, 8'h3});
        end
        wb(1'b0, ADR_SWEL, 32'h0);
        chk_val(q, {16'h4000, 8'h4, 8'h0});
        step();
        chk_val({mv, incl, resv.en, moff}, {3'b100, 16'h4000});
        chk_val(slot, m_slot + 4);
        repeat (4) step();
        $display("test switch done");
        // Forced normal join: slot follows the highest occupied foreign slot.
        wb(1'b1, ADR_CTRL, 32'h3);
        bpm_peer_i.beacon(mk(16'hff00, 8'h3));
        step();
        chk_val({mv, jn, moff}, {2'b11, 16'hff00});
        chk_val(slot, 32'h4);
        wb(1'b1, ADR_CTRL, 32'h1);
        $display("test join done");
        b = mk(16'h4000, 8'h5);
        bpm_peer_i.beacon(b);
        step();
        b.sw_pres = 1'b1;
        b.sw = '{8'h1, 16'h4000, 8'h4};
        bpm_peer_i.beacon(b);
        step();
        chk_val(sw, {8'h3, 16'hffff, 8'h0});
        chk_val(wlen, 32'h8);
        step();
        chk_val({incl, mv}, 2'b00);
        // A foreign window heard carrying an element is not made a target in that superframe.
        bpm_peer_i.beacon(b);
        step();
        chk_val({incl, mv}, 2'b00);
        $display("test halt done");
        print_verdict();
    end
endmodule // tb_top
